// [testbench/ssir_spi_master.sv]
// serial bus master model for the slave port
`timescale 1ns/10ps
module ssir_spi_master (
    input  wire logic clk,
    input  wire logic so,
    input  wire logic so_oe,
    output      logic sclk,
    output      logic si,
    output      logic chip_select_n
);
    logic oe_seen;
    initial begin
        sclk          = 1'b0;
        si            = 1'b0;
        chip_select_n = 1'b1;
        oe_seen       = 1'b0;
    end
    // ==========================================
    // one frame of n clocks, msb first; clock idles low
    task automatic xfer(input logic [31:0] d, input int n,
                        output logic [31:0] rx);
        rx = '0;
        oe_seen = 1'b1;
        @(posedge clk) chip_select_n <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = n - 1; i >= 0; i--) begin
            si <= d[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
            rx = {rx[30:0], so};
            oe_seen = oe_seen & so_oe;
        end
        repeat (4) @(posedge clk);
        chip_select_n <= 1'b1;
        si <= ~si;
        repeat (12) @(posedge clk);
    endtask
    // ==========================================
    // clock and data activity while deselected
    task automatic noise;
        repeat (5) begin
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            si   <= ~si;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
        end
    endtask
endmodule

// [testbench/tb_top.sv]
// bench for the serial port input register block
`timescale 1ns/10ps
module tb_top;
    import ssir_pkg::*;
    logic        clk;
    logic        sys_rst;
    logic        reset_n_pin;
    logic [3:0]  direct_in;
    logic [15:0] status_word;
    logic        sclk;
    logic        si;
    logic        chip_select_n;
    logic        so;
    logic        so_oe;
    logic        fail;
    logic        awake;
    ssir_cfg_t   cfg;
    logic [31:0] rx;
    logic        wd;
    int          err_count;
    int          num_checks;
    // ==========================================
    // design and master
    ssir_top #(.WD_SHORT_US(20), .WD_LONG_US(40)) u_dut (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .sclk         (sclk),
        .si           (si),
        .chip_select_n(chip_select_n),
        .reset_n_pin  (reset_n_pin),
        .direct_in    (direct_in),
        .status_word  (status_word),
        .so_ff        (so),
        .so_oe_ff     (so_oe),
        .cfg_ff       (cfg),
        .fail_ff      (fail),
        .awake_ff     (awake)
    );
    ssir_spi_master u_master (
        .clk          (clk),
        .so           (so),
        .so_oe        (so_oe),
        .sclk         (sclk),
        .si           (si),
        .chip_select_n(chip_select_n)
    );
    always #12.5 clk = ~clk;
    // ==========================================
    // tasks
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [10:0] d);
        wd = ~wd;
        u_master.xfer({16'h0000, a, wd, d}, 16, rx);
    endtask
    task automatic zero(input string nm);
        check(nm, {31'h0, cfg === '0}, 32'h1);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ==========================================
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        stop_test();
    end
    // ==========================================
    // tests
    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        reset_n_pin = 1'b1;
        direct_in = 4'h0;
        status_word = 16'hA5C3;
        wd = 1'b0;
        err_count = 0;
        num_checks = 0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk);
        zero("cfg_rst");
        check("oe_idle", so_oe, 1'b0);
        $display("reset test done");
        wr(A_CH1, 11'h5A5);
        check("status_rx", rx[15:0], 16'hA5C3);
        check("oe_frame", u_master.oe_seen, 1'b1);
        check("ch1", cfg.chan[0], 10'h2A5);
        wr(4'h7, 11'h17E);
        check("ch6", cfg.chan[5], 10'h07E);
        check("ch_en", cfg.ch_enable, 6'h21);
        wr(A_OUT_EN, 11'h7D5);
        check("out_en", {cfg.out_func_sel, cfg.ch_enable}, 11'h7D5);
        wr(A_GDUTY, 11'h02A);
        wr(A_GDUTY, 11'h4C3);
        check("gduty", {cfg.gduty_enable, cfg.gduty_cycle}, 14'h2AC3);
        wr(A_INIT_A, 11'h6B7);
        check("init_a", cfg.init_a, 11'h6B7);
        wr(A_INIT_B, 11'h2CB);
        check("init_b", cfg.init_b, 11'h2CB);
        wr(A_OC, 11'h1E3);
        wr(A_OC, 11'h7FF);
        check("oc", {cfg.lo_oc_profile, cfg.csense_mode_en,
              cfg.hi_oc_inhibit, cfg.short_oc_window}, 20'h78FFF);
        wr(A_DIN, 11'h0C6);
        check("din", cfg.din_mode, 8'hC6);
        wr(A_DIN, 11'h4FF);
        check("din_sub", cfg.din_mode, 8'hC6);
        wr(A_PRESC, 11'h2B4);
        wr(A_PRESC, 11'h403);
        check("presc", cfg.presc_sel, 12'hEB4);
        wr(A_OL, 11'h155);
        wr(A_OL, 11'h43A);
        check("ol", {cfg.ol_on_deglitch, cfg.ol_off_enable,
              cfg.led_ol_trigger, cfg.led_ol_enable}, 16'h557A);
        wr(A_TEST, 11'h7FF);
        check("test_din", cfg.din_mode, 8'hC6);
        check("test_en", cfg.ch_enable, 6'h15);
        $display("register test done");
        u_master.noise();
        check("noise_oe", so_oe, 1'b0);
        wd = ~wd;
        u_master.xfer({16'hBEEF, A_STEP, wd, 11'h5A9}, 32, rx);
        check("chain_out", rx, {16'hA5C3, 16'hBEEF});
        check("step", {cfg.duty_step_sign, cfg.duty_step}, 11'h5A9);
        check("noise_fail", fail, 1'b0);
        $display("chain test done");
        u_master.xfer({16'h0000, A_CH1, ~wd, 11'h0FF}, 15, rx);
        check("len_fail", fail, 1'b1);
        check("fail_init", cfg.init_a, 11'h007);
        check("fail_en", cfg.ch_enable, 6'h00);
        @(posedge clk) status_word <= 16'h3C5A;
        wd = 1'b1;
        wr(A_CH1, 11'h1FF);
        check("fail_rx", rx[15:0], 16'h3C5A);
        check("fail_wr", cfg.chan[0], 10'h000);
        check("armed", fail, 1'b1);
        wr(A_INIT_A, 11'h000);
        check("recover", fail, 1'b0);
        zero("recover_cfg");
        $display("fail test done");
        repeat (700) @(posedge clk);
        check("wd_early", fail, 1'b0);
        repeat (200) @(posedge clk);
        check("wd_late", fail, 1'b1);
        wd = 1'b1;
        wr(A_INIT_A, 11'h000);
        wr(A_INIT_A, 11'h000);
        wr(A_CH1, 11'h1FF);
        check("ch1_again", cfg.chan[0], 10'h0FF);
        $display("watchdog test done");
        @(posedge clk) reset_n_pin <= 1'b0;
        direct_in <= 4'h4;
        repeat (10) @(posedge clk);
        zero("pin_rst");
        check("pin_awake", awake, 1'b1);
        @(posedge clk) direct_in <= 4'h0;
        repeat (10) @(posedge clk);
        check("asleep", awake, 1'b0);
        @(posedge clk) reset_n_pin <= 1'b1;
        repeat (10) @(posedge clk);
        check("awake", awake, 1'b1);
        check("pin_fail", fail, 1'b0);
        $display("reset pin test done");
        stop_test();
    end
endmodule

// [verilog/ssir_pkg.sv]
// constants and types for the serial port input register block
package ssir_pkg;
    // ==========================================================
    // frame layout
    localparam int FRAME_BITS = 16;
    localparam int ADDR_LSB   = 12;
    localparam int WD_BIT     = 11;
    localparam int SUB_BIT    = 10;
    localparam int DATA_W     = 11;
    localparam int NUM_CH     = 6;
    localparam int NUM_PIN    = 8;
    // ==========================================================
    // register addresses
    localparam logic [3:0] A_INIT_A = 4'h0;
    localparam logic [3:0] A_INIT_B = 4'h1;
    localparam logic [3:0] A_CH1    = 4'h2;
    localparam logic [3:0] A_OUT_EN = 4'h8;
    localparam logic [3:0] A_GDUTY  = 4'h9;
    localparam logic [3:0] A_OC     = 4'hA;
    localparam logic [3:0] A_DIN    = 4'hB;
    localparam logic [3:0] A_PRESC  = 4'hC;
    localparam logic [3:0] A_OL     = 4'hD;
    localparam logic [3:0] A_STEP   = 4'hE;
    localparam logic [3:0] A_TEST   = 4'hF;
    // ==========================================================
    // field positions
    localparam int CH_EN_BIT = 8;
    localparam int HI5_LSB   = 5;
    localparam int LED_TRIG  = 5;
    localparam int OFS_LSB   = 6;
    // ==========================================================
    // timing and reset values
    localparam int CLK_MHZ = 40;
    localparam int WD_W    = 24;
    localparam logic [NUM_PIN-1:0] PIN_RST = 8'h04;
    // ==========================================================
    // types
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b001,
        MODE_FAIL   = 3'b010,
        MODE_ARMED  = 3'b100
    } ssir_mode_t;
    typedef struct packed {
        logic       wd_timeout_sel;
        logic [1:0] sync_delay_sel;
        logic [2:0] sense_mux_sel;
        logic       single_read_sel;
        logic [3:0] status_read_addr;
    } ssir_init_a_t;
    typedef struct packed {
        logic       hi_oc_thermal;
        logic       hi_oc_transient;
        logic [1:0] hold_sel;
        logic [4:0] hi_oc_disable;
        logic       pwm_sync_sel;
        logic       thermal_warn_sel;
    } ssir_init_b_t;
    typedef struct packed {
        logic [1:0] phase;
        logic [7:0] duty;
    } ssir_chan_t;
    typedef struct packed {
        ssir_init_a_t               init_a;
        ssir_init_b_t               init_b;
        ssir_chan_t [NUM_CH-1:0]    chan;
        logic [NUM_CH-1:0]          ch_enable;
        logic [4:0]                 out_func_sel;
        logic [NUM_CH-1:0]          gduty_enable;
        logic [7:0]                 gduty_cycle;
        logic [4:0]                 lo_oc_profile;
        logic [4:0]                 csense_mode_en;
        logic [4:0]                 hi_oc_inhibit;
        logic [4:0]                 short_oc_window;
        logic [7:0]                 din_mode;
        logic [11:0]                presc_sel;
        logic [4:0]                 ol_on_deglitch;
        logic [4:0]                 ol_off_enable;
        logic                       led_ol_trigger;
        logic [4:0]                 led_ol_enable;
        logic                       duty_step_sign;
        logic [9:0]                 duty_step;
    } ssir_cfg_t;
endpackage

// [verilog/ssir_top.sv]
// serial slave port and input register decode
`timescale 1ns/10ps
// Notes on behaviour
// - sixteen-bit full-duplex frames, daisy-chain capable
// - shift serial input on serial clock rise
// - update serial output on rise; master samples fall
// - select fall loads status word into shifter
// - shift only while selected; write on select rise
// - deselected: ignore clock and input, output off
// - reset pin low holds port and registers cleared
// - plausibility failure forces fail mode
// - top nibble addresses, low eleven bits data
// - missing watchdog toggle before timeout is failure
// - all input fields zero after reset
// - addresses two to seven are channel controls
// - address nine global duty enables or value
// - address ten overcurrent profile sub-registers
// - address eleven direct input modes
// - address twelve prescaler selects, two pages
// - address thirteen open-load configuration pages
// - address fourteen duty steps; fifteen test
// - clock count not multiple of sixteen fails
// - entering fail clears written settings except status read address
// - leave fail by watchdog zero then one
// - fail mode still returns selected status
module ssir_top #(
    parameter int WD_SHORT_US = 1000,
    parameter int WD_LONG_US  = 4000
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              sclk,
    input  wire logic              si,
    input  wire logic              chip_select_n,
    input  wire logic              reset_n_pin,
    input  wire logic [3:0]        direct_in,
    input  wire logic [15:0]       status_word,
    output      logic              so_ff,
    output      logic              so_oe_ff,
    output      ssir_pkg::ssir_cfg_t cfg_ff,
    output      logic              fail_ff,
    output      logic              awake_ff
);
    import ssir_pkg::*;

    localparam logic [WD_W-1:0] WD0_CYC =
        WD_W'(WD_SHORT_US * CLK_MHZ);
    localparam logic [WD_W-1:0] WD1_CYC =
        WD_W'(WD_LONG_US * CLK_MHZ);

    // ==========================================================
    // pin synchronisers
    logic [NUM_PIN-1:0] s1_ff;
    logic [NUM_PIN-1:0] s2_ff;
    logic [NUM_PIN-1:0] s3_ff;
    logic [NUM_PIN-1:0] flt_ff;
    wire  [NUM_PIN-1:0] pins;
    wire  [NUM_PIN-1:0] agree;
    wire  [NUM_PIN-1:0] nxt_flt;

    assign pins    = {direct_in, reset_n_pin, chip_select_n, si, sclk};
    assign agree   = ~(s2_ff ^ s3_ff);
    assign nxt_flt = (agree & s3_ff) | (~agree & flt_ff);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_ff  <= PIN_RST;
            s2_ff  <= PIN_RST;
            s3_ff  <= PIN_RST;
            flt_ff <= PIN_RST;
        end else begin
            s1_ff  <= pins;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            flt_ff <= nxt_flt;
        end
    end

    wire sclk_f = flt_ff[0];
    wire si_f   = flt_ff[1];
    wire csn_f  = flt_ff[2];
    wire rstn_f = flt_ff[3];
    wire [3:0] din_f = flt_ff[7:4];
    wire port_rst = sys_rst | ~rstn_f;

    // ==========================================================
    // edge detection
    logic sclk_prev_ff;
    logic csn_prev_ff;
    wire  sclk_rise = sclk_f & ~sclk_prev_ff;
    wire  csn_fall  = ~csn_f & csn_prev_ff;
    wire  csn_rise  = csn_f & ~csn_prev_ff;
    wire  shift_en  = sclk_rise & ~csn_f;

    always_ff @(posedge clk) begin
        if (port_rst) begin
            sclk_prev_ff <= 1'b0;
            csn_prev_ff  <= 1'b1;
        end else begin
            sclk_prev_ff <= sclk_f;
            csn_prev_ff  <= csn_f;
        end
    end

    // ==========================================================
    // shift register and serial output
    logic [FRAME_BITS-1:0] sh_ff;
    logic [3:0]            cnt_ff;
    logic                  got_ff;

    always_ff @(posedge clk) begin
        if (port_rst) begin
            sh_ff    <= '0;
            cnt_ff   <= 4'h0;
            got_ff   <= 1'b0;
            so_ff    <= 1'b0;
            so_oe_ff <= 1'b0;
        end else begin
            so_oe_ff <= ~csn_f;
            if (csn_fall) begin
                sh_ff  <= status_word;
                so_ff  <= status_word[FRAME_BITS-1];
                cnt_ff <= 4'h0;
                got_ff <= 1'b0;
            end else if (shift_en) begin
                sh_ff  <= {sh_ff[FRAME_BITS-2:0], si_f};
                so_ff  <= sh_ff[FRAME_BITS-2];
                cnt_ff <= cnt_ff + 4'h1;
                got_ff <= 1'b1;
            end
        end
    end

    // ==========================================================
    // frame decode
    wire [3:0]        addr   = sh_ff[FRAME_BITS-1:ADDR_LSB];
    wire              wd_bit = sh_ff[WD_BIT];
    wire [DATA_W-1:0] data   = sh_ff[DATA_W-1:0];
    wire              sub    = sh_ff[SUB_BIT];
    wire frame_ok = csn_rise & got_ff & (cnt_ff == 4'h0);
    wire len_err  = csn_rise & got_ff & (cnt_ff != 4'h0);

    // ==========================================================
    // watchdog and mode
    ssir_mode_t        mode_ff;
    ssir_mode_t        nxt_mode;
    logic [WD_W-1:0]   wd_cnt_ff;
    logic [WD_W-1:0]   nxt_wd_cnt;
    logic              wd_prev_ff;
    wire [WD_W-1:0]    wd_lim = cfg_ff.init_a.wd_timeout_sel ?
                                WD1_CYC : WD0_CYC;
    wire wd_exp = (wd_cnt_ff >= wd_lim);
    wire wd_tgl = frame_ok & (wd_bit != wd_prev_ff);
    wire normal = (mode_ff == MODE_NORMAL);
    wire wr_norm = frame_ok & normal & ~wd_exp;

    always_comb begin
        nxt_mode = mode_ff;
        case (mode_ff)
            MODE_NORMAL: begin
                if (len_err | wd_exp)
                    nxt_mode = MODE_FAIL;
            end
            MODE_FAIL: begin
                if (frame_ok & ~wd_bit)
                    nxt_mode = MODE_ARMED;
            end
            MODE_ARMED: begin
                if (len_err | wd_exp)
                    nxt_mode = MODE_FAIL;
                else if (frame_ok & wd_bit)
                    nxt_mode = MODE_NORMAL;
            end
            default: nxt_mode = MODE_FAIL;
        endcase
    end

    wire mode_chg = (nxt_mode != mode_ff);
    wire wd_rst   = mode_chg | (normal & wd_tgl) |
                    (~normal & frame_ok);

    assign nxt_wd_cnt = wd_rst ? '0 :
                        wd_exp ? wd_cnt_ff :
                        wd_cnt_ff + WD_W'(1);

    always_ff @(posedge clk) begin
        if (port_rst) begin
            mode_ff    <= MODE_NORMAL;
            fail_ff    <= 1'b0;
            wd_cnt_ff  <= '0;
            wd_prev_ff <= 1'b0;
        end else begin
            mode_ff    <= nxt_mode;
            fail_ff    <= (nxt_mode != MODE_NORMAL);
            wd_cnt_ff  <= nxt_wd_cnt;
            if (frame_ok)
                wd_prev_ff <= wd_bit;
        end
    end

    // ==========================================================
    // register writes
    wire fail_enter = normal & mode_chg;
    wire fail_exit  = ~normal & (nxt_mode == MODE_NORMAL);
    wire hit_out    = wr_norm & (addr == A_OUT_EN);
    wire fail_soa   = frame_ok & ~normal & (addr == A_INIT_A);

    wire ssir_chan_t [NUM_CH-1:0] nxt_chan;
    wire [NUM_CH-1:0]             nxt_en;
    ssir_cfg_t               nxt_cfg;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            wire hit = wr_norm & (addr == A_CH1 + 4'(g));
            assign nxt_chan[g] = hit ?
                {data[SUB_BIT:CH_EN_BIT+1], data[7:0]} :
                cfg_ff.chan[g];
            assign nxt_en[g] = hit ? data[CH_EN_BIT] :
                               hit_out ? data[g] :
                               cfg_ff.ch_enable[g];
        end
    endgenerate

    always_comb begin
        nxt_cfg           = cfg_ff;
        nxt_cfg.chan      = nxt_chan;
        nxt_cfg.ch_enable = nxt_en;
        if (wr_norm) begin
            if (addr == A_INIT_A) begin
                nxt_cfg.init_a = ssir_init_a_t'(data);
            end else if (addr == A_INIT_B) begin
                nxt_cfg.init_b = ssir_init_b_t'(data);
            end else if (addr == A_OUT_EN) begin
                nxt_cfg.out_func_sel = data[SUB_BIT:OFS_LSB];
            end else if (addr == A_GDUTY) begin
                if (sub)
                    nxt_cfg.gduty_cycle = data[7:0];
                else
                    nxt_cfg.gduty_enable = data[NUM_CH-1:0];
            end else if (addr == A_OC) begin
                if (sub) begin
                    nxt_cfg.hi_oc_inhibit   = data[9:HI5_LSB];
                    nxt_cfg.short_oc_window = data[4:0];
                end else begin
                    nxt_cfg.lo_oc_profile  = data[9:HI5_LSB];
                    nxt_cfg.csense_mode_en = data[4:0];
                end
            end else if (addr == A_DIN) begin
                if (!sub)
                    nxt_cfg.din_mode = data[7:0];
            end else if (addr == A_PRESC) begin
                if (sub)
                    nxt_cfg.presc_sel[11:10] = data[1:0];
                else
                    nxt_cfg.presc_sel[9:0] = data[9:0];
            end else if (addr == A_OL) begin
                if (sub) begin
                    nxt_cfg.led_ol_trigger = data[LED_TRIG];
                    nxt_cfg.led_ol_enable  = data[4:0];
                end else begin
                    nxt_cfg.ol_on_deglitch = data[9:HI5_LSB];
                    nxt_cfg.ol_off_enable  = data[4:0];
                end
            end else if (addr == A_STEP) begin
                nxt_cfg.duty_step_sign = data[SUB_BIT];
                nxt_cfg.duty_step = data[9:0];
            end
        end
        if (fail_soa)
            nxt_cfg.init_a.status_read_addr = data[3:0];
        if (fail_enter) begin
            nxt_cfg = '0;
            nxt_cfg.init_a.status_read_addr =
                cfg_ff.init_a.status_read_addr;
        end
        if (fail_exit)
            nxt_cfg = '0;
    end

    always_ff @(posedge clk) begin
        if (port_rst)
            cfg_ff <= '0;
        else
            cfg_ff <= nxt_cfg;
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            awake_ff <= 1'b0;
        else
            awake_ff <= rstn_f | (|din_f);
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (port_rst);

    sequence frame_s;
        csn_rise && got_ff && cnt_ff == 4'h0;
    endsequence
    sequence arm_s;
        mode_ff == MODE_FAIL ##0 frame_s ##0 !wd_bit;
    endsequence
    sequence rec_s;
        mode_ff == MODE_ARMED && !wd_exp ##0 frame_s ##0 wd_bit;
    endsequence

    load_status_a: assert property (
        csn_fall |=> sh_ff == $past(status_word) &&
                     so_ff == $past(status_word[15]))
        else $error("status not loaded at select fall");
    shift_in_a: assert property (
        shift_en && !csn_fall |=> sh_ff[0] == $past(si_f) &&
                     sh_ff[15:1] == $past(sh_ff[14:0]))
        else $error("serial input not shifted");
    so_update_a: assert property (
        shift_en && !csn_fall |=> so_ff == sh_ff[15])
        else $error("serial output not updated");
    so_float_a: assert property (
        csn_f [*2] |-> !so_oe_ff && $stable(sh_ff))
        else $error("port active while deselected");
    len_fail_a: assert property (
        csn_rise && got_ff && cnt_ff != 4'h0 |=> fail_ff)
        else $error("bad bit count did not fail");
    wd_fail_a: assert property (
        normal && wd_exp |=> fail_ff && cfg_ff.chan == '0)
        else $error("watchdog expiry did not fail");
    fail_clear_a: assert property (
        $rose(fail_ff) |-> cfg_ff.ch_enable == '0 &&
            cfg_ff.chan == '0 && cfg_ff.duty_step == '0)
        else $error("settings kept in fail mode");
    chan_write_a: assert property (
        wr_norm && addr == A_CH1 |=>
            cfg_ff.chan[0].duty == $past(data[7:0]) &&
            cfg_ff.ch_enable[0] == $past(data[8]))
        else $error("channel one not written");
    test_reg_a: assert property (
        wr_norm && addr == A_TEST |=> $stable(cfg_ff))
        else $error("test frame altered settings");
    arm_step_a: assert property (
        arm_s |=> mode_ff == MODE_ARMED)
        else $error("recovery first frame not taken");
    recover_a: assert property (
        rec_s |=> !fail_ff ##1 !fail_ff)
        else $error("recovery did not return to normal");
    fail_nowrite_a: assert property (
        frame_s ##0 !normal && addr != A_INIT_A &&
            !(mode_ff == MODE_ARMED && wd_bit && !wd_exp)
            |=> $stable(cfg_ff))
        else $error("write accepted in fail mode");
    so_drive_a: assert property (
        !csn_f [*2] |-> so_oe_ff)
        else $error("output not driven while selected");
    wd_keep_a: assert property (
        frame_s ##0 normal && !wd_exp && wd_bit == wd_prev_ff
            |=> wd_cnt_ff != '0)
        else $error("untoggled frame restarted watchdog");
    pin_reset_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        !rstn_f |=> cfg_ff == '0 && !fail_ff && !so_oe_ff)
        else $error("reset pin did not hold port in reset");
    out_en_a: assert property (
        wr_norm && addr == A_OUT_EN |=>
            cfg_ff.ch_enable == $past(data[NUM_CH-1:0]))
        else $error("output enables not written");
    step_write_a: assert property (
        wr_norm && addr == A_STEP |=>
            {cfg_ff.duty_step_sign, cfg_ff.duty_step} == $past(data))
        else $error("duty step not written");
endmodule
